/* File: rtl/crs_pkg.sv */
// constants, types and register map of the register/stack/status unit
// assumes a 4-bit data memory with 12-bit nibble addresses
package crs_pkg;
	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int NIB_W    = 4;
	localparam int ADDR_W   = 12;
	localparam int BANKS    = 4;
	localparam int REGS     = 8;
	localparam int STK_AW   = 10;
	// ------------------------------------------------------------------
	// register map (nibble addresses)
	// ------------------------------------------------------------------
	localparam logic [11:0] GREG_BASE  = 12'h000; // 32 nibbles, bank n at 8*n
	localparam logic [11:0] GREG_LAST  = 12'h01f;
	localparam logic [11:0] SP_LO_ADDR = 12'hf80;
	localparam logic [11:0] SP_HI_ADDR = 12'hf81;
	localparam logic [11:0] SBS_ADDR   = 12'hf84;
	localparam logic [11:0] PSWL_ADDR  = 12'hfb0;
	localparam logic [11:0] PSWH_ADDR  = 12'hfb1;
	// ------------------------------------------------------------------
	// general register indices and pairs
	// ------------------------------------------------------------------
	localparam logic [2:0] IDX_D = 3'h2;
	localparam logic [2:0] IDX_L = 3'h5;
	localparam logic [2:0] IDX_X = 3'h6;
	localparam logic [2:0] IDX_A = 3'h7;
	localparam logic [1:0] PAIR_DE = 2'h1;
	localparam logic [1:0] PAIR_HL = 2'h2;
	localparam logic [1:0] PAIR_XA = 2'h3;
	// ------------------------------------------------------------------
	// reset values and stack steps
	// ------------------------------------------------------------------
	localparam logic [7:0] SP_RST     = 8'h00;
	localparam logic [1:0] SBS_RST    = 2'h0;
	localparam logic [1:0] RBS_RST    = 2'h0;
	localparam logic [7:0] STEP_PAIR  = 8'h02;
	localparam logic [7:0] STEP_FRAME = 8'h06;
	localparam logic [7:0] STAT_OFS   = 8'h04; // status byte at new sp + 4
	localparam logic [1:0] IST_TOP    = 2'h2;
	// ------------------------------------------------------------------
	// commands
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		STK_NONE, STK_PUSH_PAIR, STK_PUSH_CALL, STK_PUSH_IRQ,
		STK_POP_PAIR, STK_POP_RET, STK_POP_INTERRUPT_RETURN_OP
	} crs_stk_op_t;
	typedef enum logic [3:0] {
		CY_NONE, CY_SET, CY_CLR, CY_NOT, CY_AND, CY_OR, CY_XOR, CY_LOAD, CY_ARITH
	} crs_cy_op_t;
	// status word, bit order as stored in memory
	typedef struct packed {
		logic       carry_bit;
		logic [2:0] skip_flags;     // skip_flag_2..0
		logic [1:0] irq_level;      // irq_level_hi, irq_level_lo
		logic       membank_enable;
		logic       regbank_enable;
	} crs_psw_t;
	// stack request from the sequencer
	typedef struct packed {
		crs_stk_op_t op;
		logic [1:0]  pair;   // pair for push/pop pair
		logic [7:0]  rdata;  // byte read back for pops
	} crs_stk_req_t;
	// stack write/read access toward data memory
	typedef struct packed {
		logic              valid;
		logic              write;
		logic [STK_AW-1:0] addr;  // address of lower nibble
		logic [7:0]        wdata;
	} crs_stk_acc_t;
endpackage

/* File: rtl/crs_unit.sv */
// register banks, accumulators, stack pointer and status word of the core
// assumes the sequencer issues one stack, carry or register command per cycle
//
// Summary of operation
// - four banks of eight nibble registers
// - active bank is enable AND select
// - BC DE HL XA pairs; DE HL DL pointers
// - registers also reachable as plain memory
// - A is nibble accumulator, XA byte accumulator
// - decrement before push, increment after pop
// - stack lies in banks 0-3 by selector
// - selector codes 0..3 map to banks 0..3
// - selector upper two bits read zero
// - pointer 00 pushes to top of bank
// - stack wraps inside its bank only
// - pointer and selector undefined, software initialises
// - pointer and selector readable and writable
// - low status nibble writable, high nibble not
// - calls save and returns restore bank enables
// - interrupt pushes whole status word
// - interrupt return restores whole status word
// - pair upper at sp-1, lower at sp-2
// - carry records add/sub carry out
// - carry set, clear, invert, skip test
// - carry and/or/xor/move with memory bit
// - carry undefined after reset
// - skip flags set only by execution
// - enable zero forces register bank zero
// - interrupt raises level by one step; level 2 holds and level 3 wraps to 0
// - reset clears bank select to zero
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module crs_unit (
	// clock, reset, enable
	input  wire logic                  core_clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  ce_i,
	// data memory register port
	input  wire logic [11:0]           mem_addr_i,
	input  wire logic [3:0]            mem_wdata_i,
	input  wire logic                  mem_wr_i,
	input  wire logic                  mem_rd_i,
	output logic      [3:0]            mem_rdata_o,
	// general register access from the sequencer
	input  wire logic                  reg_wr_i,
	input  wire logic [2:0]            reg_idx_i,
	input  wire logic [3:0]            reg_wdata_i,
	input  wire logic                  pair_wr_i,
	input  wire logic [1:0]            pair_sel_i,
	input  wire logic [7:0]            pair_wdata_i,
	output logic      [3:0]            acc_o,
	output logic      [7:0]            wide_accumulator_o,
	output logic      [7:0]            ptr_de_o,
	output logic      [7:0]            ptr_hl_o,
	output logic      [7:0]            ptr_dl_o,
	// bank selection
	input  wire logic                  regbank_select_wr_i,
	input  wire logic [1:0]            regbank_select_i,
	output logic      [1:0]            active_regbank_o,
	// vector load of bank enables (reset and interrupt vectors)
	input  wire logic                  vec_load_i,
	input  wire logic                  vec_mbe_i,
	input  wire logic                  vec_rbe_i,
	// stack commands and memory access
	input  wire crs_pkg::crs_stk_req_t stk_req_i,
	output crs_pkg::crs_stk_acc_t      stk_acc_o,
	// carry and skip
	input  wire crs_pkg::crs_cy_op_t   cy_op_i,
	input  wire logic                  cy_bit_i,
	input  wire logic                  skip_wr_i,
	input  wire logic [2:0]            skip_i,
	output logic                       carry_bit_o,
	output crs_pkg::crs_psw_t          psw_o
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [3:0]      greg_ff [crs_pkg::BANKS*crs_pkg::REGS]; // bank-major array
	logic [7:1]      sp_ff;       // bit 0 never stored
	logic [1:0]      sbs_ff;      // only the two live selector bits
	logic [1:0]      rbs_ff;      // register bank select
	crs_pkg::crs_psw_t psw_ff;
	logic [3:0]      rdata_ff;
	crs_pkg::crs_stk_acc_t acc_ff;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// flat index of register r in bank b
	function automatic logic [4:0] gidx(input logic [1:0] b, input logic [2:0] r);
		gidx = {b, r};
	endfunction
	// stack byte address inside bank, wraps by 8-bit arithmetic
	function automatic logic [9:0] saddr(input logic [1:0] b, input logic [7:0] p);
		saddr = {b, p};
	endfunction

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	wire logic [7:0] sp_full   = {sp_ff, 1'b0};
	wire logic [1:0] act_bank  = rbs_ff & {2{psw_ff.regbank_enable}};
	wire logic       hit_greg  = (mem_addr_i <= crs_pkg::GREG_LAST);
	wire logic       hit_spl   = (mem_addr_i == crs_pkg::SP_LO_ADDR);
	wire logic       hit_sph   = (mem_addr_i == crs_pkg::SP_HI_ADDR);
	wire logic       hit_sbs   = (mem_addr_i == crs_pkg::SBS_ADDR);
	wire logic       hit_pswl  = (mem_addr_i == crs_pkg::PSWL_ADDR);
	wire logic       hit_pswh  = (mem_addr_i == crs_pkg::PSWH_ADDR);
	wire logic [4:0] mem_gi    = mem_addr_i[4:0];
	wire logic [7:0] psw_byte  = psw_ff;

	// stack arithmetic: pushes step down first, pops step up after
	wire logic       is_push   = (stk_req_i.op == crs_pkg::STK_PUSH_PAIR) |
	                             (stk_req_i.op == crs_pkg::STK_PUSH_CALL) |
	                             (stk_req_i.op == crs_pkg::STK_PUSH_IRQ);
	wire logic       is_pop    = (stk_req_i.op == crs_pkg::STK_POP_PAIR) |
	                             (stk_req_i.op == crs_pkg::STK_POP_RET) |
	                             (stk_req_i.op == crs_pkg::STK_POP_INTERRUPT_RETURN_OP);
	wire logic       is_pairop = (stk_req_i.op == crs_pkg::STK_PUSH_PAIR) |
	                             (stk_req_i.op == crs_pkg::STK_POP_PAIR);
	wire logic [7:0] stk_step  = is_pairop ? crs_pkg::STEP_PAIR : crs_pkg::STEP_FRAME;
	// 8-bit wrap keeps the stack inside its bank; 00 minus step lands near ff
	wire logic [7:0] sp_dec    = sp_full - stk_step;
	wire logic [7:0] sp_inc    = sp_full + stk_step;
	// pair sits at new sp (lower) and new sp+1 (upper); status at new sp+4
	wire logic [7:0] push_at   = is_pairop ? sp_dec : (sp_dec + crs_pkg::STAT_OFS);
	wire logic [7:0] pop_at    = is_pairop ? sp_full : (sp_full + crs_pkg::STAT_OFS);
	wire logic [7:0] pair_val  = {greg_ff[gidx(act_bank, {stk_req_i.pair, 1'b0})],
	                              greg_ff[gidx(act_bank, {stk_req_i.pair, 1'b1})]};
	// call frames carry only the bank enables; interrupts the whole word
	wire logic [7:0] call_stat = {6'h00, psw_ff.membank_enable, psw_ff.regbank_enable};
	wire logic [7:0] stk_wbyte = (stk_req_i.op == crs_pkg::STK_PUSH_PAIR) ? pair_val :
	                             (stk_req_i.op == crs_pkg::STK_PUSH_CALL) ? call_stat :
	                             psw_byte;

	// ------------------------------------------------------------------
	// carry next value
	// ------------------------------------------------------------------
	logic nxt_cy;
	always_comb begin
		nxt_cy = psw_ff.carry_bit;
		unique case (cy_op_i)
			crs_pkg::CY_NONE:  nxt_cy = psw_ff.carry_bit;
			crs_pkg::CY_SET:   nxt_cy = 1'b1;
			crs_pkg::CY_CLR:   nxt_cy = 1'b0;
			crs_pkg::CY_NOT:   nxt_cy = ~psw_ff.carry_bit;
			crs_pkg::CY_AND:   nxt_cy = psw_ff.carry_bit & cy_bit_i;
			crs_pkg::CY_OR:    nxt_cy = psw_ff.carry_bit | cy_bit_i;
			crs_pkg::CY_XOR:   nxt_cy = psw_ff.carry_bit ^ cy_bit_i;
			crs_pkg::CY_LOAD:  nxt_cy = cy_bit_i;
			crs_pkg::CY_ARITH: nxt_cy = cy_bit_i;
			default:           nxt_cy = psw_ff.carry_bit;                     // illegal code holds
		endcase
	end

	// ------------------------------------------------------------------
	// status word next value; sequencer commands win over memory writes
	// ------------------------------------------------------------------
	crs_pkg::crs_psw_t nxt_psw;
	always_comb begin
		nxt_psw = psw_ff;
		// low nibble is ordinary memory; high nibble has no memory write path
		if (mem_wr_i && hit_pswl) begin
			nxt_psw.irq_level      = mem_wdata_i[3:2];
			nxt_psw.membank_enable = mem_wdata_i[1];
			nxt_psw.regbank_enable = mem_wdata_i[0];
		end
		if (vec_load_i) begin
			nxt_psw.membank_enable = vec_mbe_i;
			nxt_psw.regbank_enable = vec_rbe_i;
		end
		if (skip_wr_i) begin
			nxt_psw.skip_flags = skip_i;
		end
		nxt_psw.carry_bit = nxt_cy;
		if (stk_req_i.op == crs_pkg::STK_PUSH_IRQ && psw_ff.irq_level != crs_pkg::IST_TOP) begin
			nxt_psw.irq_level = psw_ff.irq_level + 2'h1;
		end
		if (stk_req_i.op == crs_pkg::STK_POP_RET) begin
			nxt_psw.membank_enable = stk_req_i.rdata[1];
			nxt_psw.regbank_enable = stk_req_i.rdata[0];
		end
		if (stk_req_i.op == crs_pkg::STK_POP_INTERRUPT_RETURN_OP) begin
			nxt_psw = stk_req_i.rdata;
		end
	end

	// ------------------------------------------------------------------
	// stack pointer and selector next values
	// ------------------------------------------------------------------
	wire logic [7:0] nxt_sp  = is_push ? sp_dec :
	                           is_pop  ? sp_inc :
	                           (mem_wr_i && hit_spl) ? {sp_full[7:4], mem_wdata_i[3:1], 1'b0} :
	                           (mem_wr_i && hit_sph) ? {mem_wdata_i, sp_full[3:0]} :
	                           sp_full;
	// only the low two selector bits are kept, so the upper two stay zero
	wire logic [1:0] nxt_sbs = (mem_wr_i && hit_sbs) ? mem_wdata_i[1:0] : sbs_ff;
	wire logic [1:0] nxt_rbs = regbank_select_wr_i ? regbank_select_i : rbs_ff;

	// ------------------------------------------------------------------
	// memory read mux
	// ------------------------------------------------------------------
	wire logic [3:0] rd_mux = hit_greg ? greg_ff[mem_gi] :
	                          hit_spl  ? sp_full[3:0] :
	                          hit_sph  ? sp_full[7:4] :
	                          hit_sbs  ? {2'b00, sbs_ff} :
	                          hit_pswl ? psw_byte[3:0] :
	                          hit_pswh ? psw_byte[7:4] :
	                          4'h0;                                          // unmapped reads zero

	// ------------------------------------------------------------------
	// control registers
	// pointer, selector and carry reset to zero here; software may not rely on it
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sp_ff  <= crs_pkg::SP_RST[7:1];
			sbs_ff <= crs_pkg::SBS_RST;
			rbs_ff <= crs_pkg::RBS_RST;
			psw_ff <= '0;
		end else if (ce_i) begin
			sp_ff  <= nxt_sp[7:1];
			sbs_ff <= nxt_sbs;
			rbs_ff <= nxt_rbs;
			psw_ff <= nxt_psw;
		end
	end

	// ------------------------------------------------------------------
	// read data and stack access registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_ff <= 4'h0;
			acc_ff   <= '0;
		end else if (ce_i) begin
			rdata_ff     <= mem_rd_i ? rd_mux : 4'h0;
			acc_ff.valid <= is_push | is_pop;
			acc_ff.write <= is_push;
			acc_ff.addr  <= saddr(sbs_ff, is_push ? push_at : pop_at);
			acc_ff.wdata <= is_push ? stk_wbyte : 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// general register file
	// priority: popped pair, then pair write, then nibble write, then memory
	// the array is not reset; its contents are data, not control state
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (ce_i) begin
			if (mem_wr_i && hit_greg) begin
				greg_ff[mem_gi] <= mem_wdata_i;
			end
			if (reg_wr_i) begin
				greg_ff[gidx(act_bank, reg_idx_i)] <= reg_wdata_i;
			end
			if (pair_wr_i) begin
				greg_ff[gidx(act_bank, {pair_sel_i, 1'b0})] <= pair_wdata_i[7:4];
				greg_ff[gidx(act_bank, {pair_sel_i, 1'b1})] <= pair_wdata_i[3:0];
			end
			if (stk_req_i.op == crs_pkg::STK_POP_PAIR) begin
				greg_ff[gidx(act_bank, {stk_req_i.pair, 1'b0})] <= stk_req_i.rdata[7:4];
				greg_ff[gidx(act_bank, {stk_req_i.pair, 1'b1})] <= stk_req_i.rdata[3:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign mem_rdata_o        = rdata_ff;
	assign stk_acc_o          = acc_ff;
	assign active_regbank_o   = act_bank;
	assign acc_o              = greg_ff[gidx(act_bank, crs_pkg::IDX_A)];
	assign wide_accumulator_o = {greg_ff[gidx(act_bank, crs_pkg::IDX_X)],
	                             greg_ff[gidx(act_bank, crs_pkg::IDX_A)]};
	assign ptr_de_o = {greg_ff[gidx(act_bank, {crs_pkg::PAIR_DE, 1'b0})],
	                   greg_ff[gidx(act_bank, {crs_pkg::PAIR_DE, 1'b1})]};
	assign ptr_hl_o = {greg_ff[gidx(act_bank, {crs_pkg::PAIR_HL, 1'b0})],
	                   greg_ff[gidx(act_bank, {crs_pkg::PAIR_HL, 1'b1})]};
	assign ptr_dl_o = {greg_ff[gidx(act_bank, crs_pkg::IDX_D)],
	                   greg_ff[gidx(act_bank, crs_pkg::IDX_L)]};
	assign carry_bit_o = psw_ff.carry_bit;                                  // skip test reads this
	assign psw_o       = psw_ff;
endmodule // crs_unit
`default_nettype wire

/* File: verification/crs_unit_properties.sv */
// concurrent checks on the ports of the register, stack and status unit
// assumes one core clock and the asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module crs_unit_properties (
	// clock, reset, enable
	input wire logic                  core_clk_i,
	input wire logic                  arst_n_i,
	input wire logic                  ce_i,
	// register port
	input wire logic [11:0]           mem_addr_i,
	input wire logic                  mem_wr_i,
	input wire logic                  mem_rd_i,
	input wire logic [3:0]            mem_rdata_o,
	// banks, stack, carry and status
	input wire logic [1:0]            active_regbank_o,
	input wire crs_pkg::crs_stk_req_t stk_req_i,
	input wire crs_pkg::crs_stk_acc_t stk_acc_o,
	input wire crs_pkg::crs_cy_op_t   cy_op_i,
	input wire logic                  skip_wr_i,
	input wire logic                  carry_bit_o,
	input wire crs_pkg::crs_psw_t     psw_o
);
	// ----------------------------------------
	// clocking and command sequences
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// a memory write beside a stack command could change the selector, so exclude it
	sequence s_push_pair;
		ce_i && !mem_wr_i && stk_req_i.op == crs_pkg::STK_PUSH_PAIR;
	endsequence
	sequence s_pop_pair;
		ce_i && !mem_wr_i && stk_req_i.op == crs_pkg::STK_POP_PAIR;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_push_pop_same: assert property (
		s_push_pair ##1 s_pop_pair |=> stk_acc_o.addr == $past(stk_acc_o.addr))
		else $error("pop after push does not reuse the pushed address");
	a_push_step_two: assert property (
		s_push_pair ##1 s_push_pair |=> stk_acc_o.addr ==
		{$past(stk_acc_o.addr[9:8]), $past(stk_acc_o.addr[7:0]) - 8'h02})
		else $error("second push not two below the first in the same bank");
	a_carry_set: assert property (
		ce_i && cy_op_i == crs_pkg::CY_SET && stk_req_i.op != crs_pkg::STK_POP_INTERRUPT_RETURN_OP
		|=> carry_bit_o == 1'b1) else $error("carry not set");
	a_carry_invert: assert property (
		ce_i && cy_op_i == crs_pkg::CY_NOT && stk_req_i.op != crs_pkg::STK_POP_INTERRUPT_RETURN_OP
		|=> carry_bit_o == !$past(carry_bit_o)) else $error("carry not inverted");
	a_irq_save_all: assert property (
		ce_i && stk_req_i.op == crs_pkg::STK_PUSH_IRQ
		|=> stk_acc_o.write && stk_acc_o.wdata == $past(psw_o))
		else $error("interrupt push does not carry the whole status");
	a_irq_level_step: assert property (
		ce_i && stk_req_i.op == crs_pkg::STK_PUSH_IRQ && psw_o.irq_level < 2'h2
		|=> psw_o.irq_level == $past(psw_o.irq_level) + 2'h1)
		else $error("interrupt level not raised by one");
	a_interrupt_return_op_restore: assert property (
		ce_i && stk_req_i.op == crs_pkg::STK_POP_INTERRUPT_RETURN_OP |=> psw_o == $past(stk_req_i.rdata))
		else $error("interrupt return does not restore the status");
	a_call_saves_enables: assert property (
		ce_i && stk_req_i.op == crs_pkg::STK_PUSH_CALL |=> stk_acc_o.wdata ==
		{6'h00, $past(psw_o.membank_enable), $past(psw_o.regbank_enable)})
		else $error("call push does not hold only the bank enables");
	a_rbe_zero_bank: assert property (
		!psw_o.regbank_enable |-> active_regbank_o == 2'h0)
		else $error("bank other than zero while bank enable is low");
	a_sbs_upper_zero: assert property (
		ce_i && mem_rd_i && mem_addr_i == crs_pkg::SBS_ADDR |=> mem_rdata_o[3:2] == 2'h0)
		else $error("stack bank selector upper bits not zero");
	a_sp_bit_zero: assert property (
		ce_i && mem_rd_i && mem_addr_i == crs_pkg::SP_LO_ADDR |=> mem_rdata_o[0] == 1'b0)
		else $error("stack pointer bit zero reads one");
	a_pswh_locked: assert property (
		ce_i && mem_wr_i && mem_addr_i == crs_pkg::PSWH_ADDR && cy_op_i == crs_pkg::CY_NONE
		&& !skip_wr_i && stk_req_i.op == crs_pkg::STK_NONE |=> $stable(psw_o[7:4]))
		else $error("upper status nibble changed by a memory write");
endmodule // crs_unit_properties

bind crs_unit crs_unit_properties i_crs_unit_properties (
	.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .mem_addr_i(mem_addr_i),
	.mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i), .mem_rdata_o(mem_rdata_o),
	.active_regbank_o(active_regbank_o), .stk_req_i(stk_req_i), .stk_acc_o(stk_acc_o),
	.cy_op_i(cy_op_i), .skip_wr_i(skip_wr_i), .carry_bit_o(carry_bit_o), .psw_o(psw_o));
`default_nettype wire

/* File: verification/crs_unit_tb.sv */
// self-checking bench for the register, stack and status unit
// assumes the checker binds itself; one 250 MHz clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module crs_unit_tb;
	// ----------------------------------------
	// stimulus, outputs and bench state
	// ----------------------------------------
	logic                  core_clk_i = 1'b0;
	logic                  arst_n_i = 1'b0;
	logic                  ce_i = 1'b1;          // held high: freeze is not exercised
	logic [11:0]           mem_addr_i = 12'h000;
	logic [3:0]            mem_wdata_i = 4'h0, reg_wdata_i = 4'h0, mem_rdata_o, acc_o;
	logic                  mem_wr_i = 1'b0, mem_rd_i = 1'b0, reg_wr_i = 1'b0, pair_wr_i = 1'b0;
	logic [2:0]            reg_idx_i = 3'h0, skip_i = 3'h0;
	logic [1:0]            pair_sel_i = 2'h0, regbank_select_i = 2'h0, active_regbank_o;
	logic [7:0]            pair_wdata_i = 8'h00, wide_accumulator_o, ptr_de_o, ptr_hl_o, ptr_dl_o;
	logic                  regbank_select_wr_i = 1'b0, vec_load_i = 1'b0, vec_mbe_i = 1'b0;
	logic                  vec_rbe_i = 1'b0, cy_bit_i = 1'b0, skip_wr_i = 1'b0, carry_bit_o;
	crs_pkg::crs_stk_req_t stk_req_i = '{op: crs_pkg::STK_NONE, pair: 2'h0, rdata: 8'h00};
	crs_pkg::crs_stk_acc_t stk_acc_o, e;
	crs_pkg::crs_cy_op_t   cy_op_i = crs_pkg::CY_NONE;
	crs_pkg::crs_psw_t     psw_o;
	crs_pkg::crs_cy_op_t   ops[10] = '{crs_pkg::CY_CLR, crs_pkg::CY_SET, crs_pkg::CY_NOT,
		crs_pkg::CY_AND, crs_pkg::CY_OR, crs_pkg::CY_XOR, crs_pkg::CY_LOAD, crs_pkg::CY_ARITH,
		crs_pkg::CY_NOT, crs_pkg::CY_SET};
	int                    seed = 83, fail_count = 0, samples_checked = 0, k;
	logic [3:0]            rd_q[$];              // expected read data, oldest first
	crs_pkg::crs_stk_acc_t acc_q[$];             // expected stack accesses
	logic [3:0]            gr[32];               // model of the general register area
	logic                  rd_seen = 1'b0, cy_m = 1'b0, b;
	logic [7:0]            de, hl;

	// every bench signal carries the port's own name
	crs_unit i_crs_unit (.*);

	initial forever #2 core_clk_i = ~core_clk_i;
	// ----------------------------------------
	// helpers: compare, bus cycles, commands
	// ----------------------------------------
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [3:0] d);
		@(posedge core_clk_i);
		mem_addr_i <= a;
		mem_wdata_i <= d;
		mem_wr_i <= 1'b1;
		@(posedge core_clk_i);
		mem_wr_i <= 1'b0;
	endtask
	// read strobe; the monitor checks the answer one cycle later
	task automatic rd(input logic [11:0] a, input logic [3:0] exp);
		@(posedge core_clk_i);
		mem_addr_i <= a;
		mem_rd_i <= 1'b1;
		rd_q.push_back(exp);
		@(posedge core_clk_i);
		mem_rd_i <= 1'b0;
	endtask
	// stack command held one cycle; caller releases it, so commands run back to back
	task automatic stk(input crs_pkg::crs_stk_op_t op, input logic [1:0] pr,
		input logic [7:0] rdat, input logic [7:0] ad, input logic w, input logic [7:0] wd);
		acc_q.push_back('{valid: 1'b1, write: w, addr: {2'h1, ad}, wdata: wd});
		stk_req_i <= '{op: op, pair: pr, rdata: rdat};
		@(posedge core_clk_i);
	endtask
	task automatic wrap_up();
		if (rd_q.size() != 0 || acc_q.size() != 0) fail_count++;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// monitor: oldest note against what appears
	// ----------------------------------------
	always @(negedge core_clk_i) begin
		if (rd_seen) chk("read data", {8'h00, rd_q.pop_front()}, {8'h00, mem_rdata_o});
		if (stk_acc_o.valid === 1'b1) begin
			e = acc_q.pop_front();
			chk("stack address", {e.write, 1'b0, e.addr}, {stk_acc_o.write, 1'b0, stk_acc_o.addr});
			if (e.write) chk("stack data", {4'h0, e.wdata}, {4'h0, stk_acc_o.wdata});
		end
		rd_seen = mem_rd_i;
	end
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk_i);
		fail_count++;
		wrap_up();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			gr[i] = 4'($random(seed));
			wr(12'(i), gr[i]);
		end
		for (int i = 0; i < 32; i++) rd(12'(i), gr[i]);
		// every select with the enable low then high
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk_i);
			regbank_select_i <= 2'(i >> 1);
			regbank_select_wr_i <= 1'b1;
			vec_load_i <= 1'b1;
			vec_mbe_i <= 1'b1;
			vec_rbe_i <= i[0];
			@(posedge core_clk_i);
			regbank_select_wr_i <= 1'b0;
			vec_load_i <= 1'b0;
			#1;
			k = i[0] ? 8 * (i >> 1) : 0;
			chk("active bank", 12'(k / 8), {10'h000, active_regbank_o});
			chk("acc", {8'h00, gr[k + 7]}, {8'h00, acc_o});
			chk("wide acc", {4'h0, gr[k + 6], gr[k + 7]}, {4'h0, wide_accumulator_o});
			chk("ptr de", {4'h0, gr[k + 2], gr[k + 3]}, {4'h0, ptr_de_o});
			chk("ptr hl", {4'h0, gr[k + 4], gr[k + 5]}, {4'h0, ptr_hl_o});
			chk("ptr dl", {4'h0, gr[k + 2], gr[k + 5]}, {4'h0, ptr_dl_o});
		end
		// bank 3 active: nibble and pair writes land in plain memory too
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_idx_i <= crs_pkg::IDX_A;
		reg_wdata_i <= 4'($random(seed));
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		rd(12'h01f, reg_wdata_i);
		@(posedge core_clk_i);
		pair_wr_i <= 1'b1;
		pair_sel_i <= crs_pkg::PAIR_HL;
		pair_wdata_i <= 8'($random(seed));
		@(posedge core_clk_i);
		pair_wr_i <= 1'b0;
		hl = pair_wdata_i;
		de = {gr[26], gr[27]};
		rd(12'h01c, hl[7:4]);
		// carry operations from a table with random memory bits
		wr(crs_pkg::PSWL_ADDR, 4'h3);
		rd(crs_pkg::PSWL_ADDR, 4'h3);
		foreach (ops[i]) begin
			b = 1'($random(seed));
			case (ops[i])
				crs_pkg::CY_SET: cy_m = 1'b1;
				crs_pkg::CY_CLR: cy_m = 1'b0;
				crs_pkg::CY_NOT: cy_m = ~cy_m;
				crs_pkg::CY_AND: cy_m = cy_m & b;
				crs_pkg::CY_OR: cy_m = cy_m | b;
				crs_pkg::CY_XOR: cy_m = cy_m ^ b;
				default: cy_m = b;
			endcase
			@(posedge core_clk_i);
			cy_op_i <= ops[i];
			cy_bit_i <= b;
			@(posedge core_clk_i);
			cy_op_i <= crs_pkg::CY_NONE;
			#1;
			chk("carry", {11'h000, cy_m}, {11'h000, carry_bit_o});
		end
		@(posedge core_clk_i);
		skip_i <= 3'h5;
		skip_wr_i <= 1'b1;
		@(posedge core_clk_i);
		skip_wr_i <= 1'b0;
		wr(crs_pkg::PSWH_ADDR, 4'h0);
		rd(crs_pkg::PSWH_ADDR, 4'hd);
		// stack set up in bank 1 from pointer zero
		wr(crs_pkg::SBS_ADDR, 4'hd);
		rd(crs_pkg::SBS_ADDR, 4'h1);
		wr(crs_pkg::SP_LO_ADDR, 4'h7);
		rd(crs_pkg::SP_LO_ADDR, 4'h6);
		wr(crs_pkg::SP_LO_ADDR, 4'h0);
		wr(crs_pkg::SP_HI_ADDR, 4'h0);
		stk(crs_pkg::STK_PUSH_PAIR, crs_pkg::PAIR_DE, 8'h00, 8'hfe, 1'b1, de);
		stk(crs_pkg::STK_PUSH_PAIR, crs_pkg::PAIR_HL, 8'h00, 8'hfc, 1'b1, hl);
		stk(crs_pkg::STK_PUSH_CALL, 2'h0, 8'h00, 8'hfa, 1'b1, 8'h03);
		stk(crs_pkg::STK_PUSH_IRQ, 2'h0, 8'h00, 8'hf4, 1'b1, 8'hd3);
		stk_req_i <= '{op: crs_pkg::STK_NONE, pair: 2'h0, rdata: 8'h00};
		rd(crs_pkg::PSWL_ADDR, 4'h7);
		stk(crs_pkg::STK_POP_INTERRUPT_RETURN_OP, 2'h0, 8'h26, 8'hf4, 1'b0, 8'h00);
		stk(crs_pkg::STK_POP_RET, 2'h0, 8'hfd, 8'hfa, 1'b0, 8'h00);
		stk(crs_pkg::STK_POP_PAIR, crs_pkg::PAIR_HL, 8'h5a, 8'hfc, 1'b0, 8'h00);
		stk(crs_pkg::STK_POP_PAIR, crs_pkg::PAIR_DE, 8'hc3, 8'hfe, 1'b0, 8'h00);
		stk(crs_pkg::STK_PUSH_PAIR, crs_pkg::PAIR_DE, 8'h00, 8'hfe, 1'b1, 8'hc3);
		stk(crs_pkg::STK_POP_PAIR, crs_pkg::PAIR_DE, 8'h81, 8'hfe, 1'b0, 8'h00);
		stk_req_i <= '{op: crs_pkg::STK_NONE, pair: 2'h0, rdata: 8'h00};
		#1;
		chk("ptr hl", 12'h05a, {4'h0, ptr_hl_o});
		chk("ptr de", 12'h081, {4'h0, ptr_de_o});
		chk("carry", 12'h000, {11'h000, carry_bit_o});
		rd(crs_pkg::PSWL_ADDR, 4'h5);
		rd(crs_pkg::PSWH_ADDR, 4'h2);
		rd(crs_pkg::SP_LO_ADDR, 4'h0);
		rd(crs_pkg::SP_HI_ADDR, 4'h0);
		rd(12'h7a3, 4'h0);
		repeat (3) @(posedge core_clk_i);
		wrap_up();
	end
endmodule // crs_unit_tb
`default_nettype wire
